// ---- logic/caf_consts.svh ----
/*
 Constants of the CAN acceptance filter and message buffer block.
 Assumes inclusion by bare name from the top module.
*/
// Functional notes
// (R1) Two-bit mode picks 2x32, 4x16, 8x8 bit filters, or all closed.
// (R2) Closed mode accepts nothing; front slot never reloads.
// (R3) Hit index 0..7 names the filter that matched the front slot message.
// (R4) Hit index updates when a message moves into the front slot.
// (R5) Zero mask bit needs code bit equal to identifier bit; all must match.
// (R6) Rx and tx buffers share a 16-byte slot with 13 data bytes.
// (R7) Only transmit buffers carry a software-written priority rank.
// (R8) With time stamp enabled, 16-bit timer is stored after each message.
// (R9) Time stamp bytes written by hardware only; CPU writes ignored.
// (R10) Masks read anytime; written only while init request and ack are set.
// (R11) Factory test register is not reachable in normal operation.
// (R12) 16 and 8 bit filters compare only the leading identifier bits covered.
`ifndef CAF_CONSTS_SVH
`define CAF_CONSTS_SVH
`define CAF_OFS_CTRL 8'h00
`define CAF_OFS_ACC 8'h04
`define CAF_OFS_STAT 8'h08
`define CAF_OFS_TEST 8'h0C
`define CAF_OFS_CODE 8'h10
`define CAF_OFS_MASK 8'h20
`define CAF_OFS_RXBUF 8'h40
`define CAF_OFS_TXBUF 8'h80
`define CAF_BUF_BYTES 16
`define CAF_BUF_DATA 13
`define CAF_ACC_ORG_LSB 4
`define CAF_ACC_HIT_LSB 0
`define CAF_CTRL_INIT_REQUEST 0
`define CAF_CTRL_TSEN 1
`define CAF_RST_MASK 8'hFF
`endif

// ---- logic/caf_pkg.sv ----
/*
 Types of the CAN acceptance filter block.
 Assumes the constants header is on the include path.
*/
package caf_pkg;
    typedef enum logic [1:0] {
        CAF_ORG_32 = 2'h0,
        CAF_ORG_16 = 2'h1,
        CAF_ORG_8 = 2'h2,
        CAF_ORG_CLOSED = 2'h3
    } caf_org_t;
    typedef struct packed {
        logic valid;
        logic [31:0] ident;
        logic [7:0] len;
        logic [63:0] data;
    } caf_rxmsg_t;
    typedef struct packed {
        logic valid;
        logic rx;
        logic [15:0] timer;
    } caf_done_t;
endpackage : caf_pkg

// ---- logic/caf_top.sv ----
/*
 Acceptance filter, front slot message buffer, tx buffer and time stamps.
 Assumes the protocol engine delivers frames and done events on sys_clk.
*/
`include "caf_consts.svh"
module caf_top (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire caf_pkg::caf_rxmsg_t rx_msg,
    input wire caf_pkg::caf_done_t done_evt,
    input wire logic init_acknowledge,
    output logic init_request,
    output logic rx_front_full,
    output logic [7:0] tx_buffer_rank
);
    import caf_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] code_q [0:7];
    logic [7:0] ident_bit_ignore_q [0:7];
    logic [7:0] rx_front_slot_q [0:15];
    logic [7:0] txbuf_q [0:15];
    logic [1:0] filter_org_select_q;
    logic [2:0] matched_filter_index_q;
    logic tsen_q;
    logic full_q;
    logic ack_q;
    logic ack_s;
    logic ack_pend_q;
    logic [31:0] rdata_q;
    logic init_mode;
    logic hit;
    logic [2:0] hit_idx;
    logic wr_go;
    logic rd_go;
    logic wr_ctrl;
    logic wr_acc;
    logic clr_front;
    logic load_front;
    logic stamp_rx;
    logic stamp_tx;

    // Byte compare under mask; a set mask bit removes the bit
    function automatic logic byte_ok(input logic [7:0] id,
        input logic [7:0] cd, input logic [7:0] mk);
        byte_ok = &(~(id ^ cd) | mk); // R5
    endfunction : byte_ok

    // Lane merge shared by the code, mask and tx buffer words
    function automatic logic [7:0] lane(input logic [7:0] old,
        input logic [31:0] wd, input logic [3:0] be, input int n);
        lane = be[n] ? wd[8*n +: 8] : old;
    endfunction : lane

    // Word view of four stored bytes, byte 0 in the low lane
    function automatic logic [31:0] pack4(input logic [7:0] b0,
        input logic [7:0] b1, input logic [7:0] b2, input logic [7:0] b3);
        pack4 = {b3, b2, b1, b0};
    endfunction : pack4

    ////////////////////////////////////////////////////////////////////////
    // One wait cycle so every access answers on its second edge
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            avs_waitrequest <= 1'b1;
        end else if ((avs_read || avs_write) && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end
    assign wr_go = avs_write && !avs_waitrequest;
    assign rd_go = avs_read && avs_waitrequest;

    // Write decode of the control, acceptance and status words kept in one place so they agree on it
    assign wr_ctrl = wr_go && avs_address == `CAF_OFS_CTRL
        && avs_byteenable[0];
    assign wr_acc = wr_go && init_mode && avs_address == `CAF_OFS_ACC
        && avs_byteenable[0];
    assign clr_front = wr_go && avs_address == `CAF_OFS_STAT
        && avs_byteenable[0] && avs_writedata[0];

    // Acknowledge arrives from another block, so synchronise it
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ack_pend_q <= 1'b0;
            ack_q <= 1'b0;
        end else begin
            ack_pend_q <= init_acknowledge;
            ack_q <= ack_pend_q;
        end
    end
    assign ack_s = ack_q;
    assign init_mode = init_request && ack_s; // R10

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            init_request <= 1'b1;
            tsen_q <= 1'b0;
        end else if (wr_ctrl) begin
            init_request <= avs_writedata[`CAF_CTRL_INIT_REQUEST];
            tsen_q <= avs_writedata[`CAF_CTRL_TSEN];
        end
    end

    // Organisation is configuration, so only init mode may change it
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            filter_org_select_q <= 2'h0;
        end else if (wr_acc) begin
            filter_org_select_q <=
                avs_writedata[`CAF_ACC_ORG_LSB +: 2]; // R1
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < 8; i++) begin
                code_q[i] <= 8'h00;
                ident_bit_ignore_q[i] <= `CAF_RST_MASK;
            end
        end else if (wr_go && init_mode) begin // R10
            for (int i = 0; i < 8; i++) begin
                if (avs_address == `CAF_OFS_CODE + 8'(4 * (i / 4)))
                    code_q[i] <= lane(code_q[i], avs_writedata,
                        avs_byteenable, i % 4);
                if (avs_address == `CAF_OFS_MASK + 8'(4 * (i / 4)))
                    ident_bit_ignore_q[i] <= lane(ident_bit_ignore_q[i],
                        avs_writedata, avs_byteenable, i % 4);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Filters in priority order; lowest index wins on multiple hits
    always_comb begin
        logic [7:0] ok;
        ok = 8'h00;
        for (int i = 0; i < 8; i++) begin
            ok[i] = byte_ok(rx_msg.ident[31 - 8*(i % 4) -: 8], code_q[i],
                ident_bit_ignore_q[i]);
        end
        hit = 1'b0;
        hit_idx = 3'h0;
        case (caf_org_t'(filter_org_select_q)) // R1
            CAF_ORG_32: begin
                if (&ok[3:0]) begin
                    hit = 1'b1;
                    hit_idx = 3'h0;
                end else if (&ok[7:4]) begin
                    hit = 1'b1;
                    hit_idx = 3'h1;
                end
            end
            CAF_ORG_16: begin
                // Each filter sees only the leading two identifier bytes
                for (int f = 3; f >= 0; f--) begin
                    if (byte_ok(rx_msg.ident[31:24], code_q[2*f],
                            ident_bit_ignore_q[2*f]) &&
                        byte_ok(rx_msg.ident[23:16], code_q[2*f+1],
                            ident_bit_ignore_q[2*f+1])) begin // R12
                        hit = 1'b1;
                        hit_idx = 3'(f);
                    end
                end
            end
            CAF_ORG_8: begin
                for (int f = 7; f >= 0; f--) begin
                    if (byte_ok(rx_msg.ident[31:24], code_q[f],
                            ident_bit_ignore_q[f])) begin // R12
                        hit = 1'b1;
                        hit_idx = 3'(f);
                    end
                end
            end
            default: begin
                hit = 1'b0; // R2
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Frames only load an empty slot; closed mode never hits
    assign load_front = rx_msg.valid && hit && !full_q; // R2
    assign stamp_rx = done_evt.valid && done_evt.rx && tsen_q; // R8
    assign stamp_tx = done_evt.valid && !done_evt.rx && tsen_q; // R8

    // Front slot reload; software frees it by writing the status word.
    // A new frame in the clearing cycle still sees the slot full and is dropped.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            full_q <= 1'b0;
            for (int b = 0; b < `CAF_BUF_BYTES; b++)
                rx_front_slot_q[b] <= 8'h00;
        end else begin
            if (clr_front)
                full_q <= 1'b0;
            if (load_front) begin // R2
                full_q <= 1'b1;
                rx_front_slot_q[0] <= rx_msg.ident[31:24];
                rx_front_slot_q[1] <= rx_msg.ident[23:16];
                rx_front_slot_q[2] <= rx_msg.ident[15:8];
                rx_front_slot_q[3] <= rx_msg.ident[7:0];
                rx_front_slot_q[4] <= rx_msg.data[63:56];
                rx_front_slot_q[5] <= rx_msg.data[55:48];
                rx_front_slot_q[6] <= rx_msg.data[47:40];
                rx_front_slot_q[7] <= rx_msg.data[39:32];
                rx_front_slot_q[8] <= rx_msg.data[31:24];
                rx_front_slot_q[9] <= rx_msg.data[23:16];
                rx_front_slot_q[10] <= rx_msg.data[15:8];
                rx_front_slot_q[11] <= rx_msg.data[7:0];
                rx_front_slot_q[12] <= rx_msg.len; // R6
            end
            if (stamp_rx) begin // R8
                rx_front_slot_q[14] <= done_evt.timer[15:8];
                rx_front_slot_q[15] <= done_evt.timer[7:0];
            end
        end
    end

    // Index moves only with the slot contents it describes
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            matched_filter_index_q <= 3'h0;
        end else if (load_front) begin
            matched_filter_index_q <= hit_idx; // R3 R4
        end
    end

    // Tx buffer: 13 data bytes, rank byte, and hardware-only stamp
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            for (int b = 0; b < `CAF_BUF_BYTES; b++)
                txbuf_q[b] <= 8'h00;
        end else begin
            for (int b = 0; b < 14; b++) begin // R6 R7 R9
                if (wr_go && avs_address == `CAF_OFS_TXBUF + 8'(4*(b/4)))
                    txbuf_q[b] <= lane(txbuf_q[b], avs_writedata,
                        avs_byteenable, b % 4);
            end
            if (stamp_tx) begin // R8 R9
                txbuf_q[14] <= done_evt.timer[15:8];
                txbuf_q[15] <= done_evt.timer[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Test word reads zero and drops writes: unreachable in normal use
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rdata_q <= 32'h0000_0000;
        end else if (rd_go) begin
            case (avs_address)
                `CAF_OFS_CTRL: begin
                    rdata_q <= {30'h0, tsen_q, init_request};
                end
                `CAF_OFS_ACC: begin
                    rdata_q <= {24'h0, 2'h0, filter_org_select_q, 1'b0,
                        matched_filter_index_q}; // R3
                end
                `CAF_OFS_STAT: begin
                    rdata_q <= {29'h0, ack_s, init_mode, full_q};
                end
                `CAF_OFS_TEST: begin
                    rdata_q <= 32'h0000_0000; // R11
                end
                `CAF_OFS_CODE: begin
                    rdata_q <= pack4(code_q[0], code_q[1], code_q[2],
                        code_q[3]);
                end
                `CAF_OFS_CODE + 8'h04: begin
                    rdata_q <= pack4(code_q[4], code_q[5], code_q[6],
                        code_q[7]);
                end
                `CAF_OFS_MASK: begin
                    rdata_q <= pack4(ident_bit_ignore_q[0],
                        ident_bit_ignore_q[1], ident_bit_ignore_q[2],
                        ident_bit_ignore_q[3]); // R10
                end
                `CAF_OFS_MASK + 8'h04: begin
                    rdata_q <= pack4(ident_bit_ignore_q[4],
                        ident_bit_ignore_q[5], ident_bit_ignore_q[6],
                        ident_bit_ignore_q[7]); // R10
                end
                `CAF_OFS_RXBUF: begin
                    rdata_q <= pack4(rx_front_slot_q[0],
                        rx_front_slot_q[1], rx_front_slot_q[2],
                        rx_front_slot_q[3]);
                end
                `CAF_OFS_RXBUF + 8'h04: begin
                    rdata_q <= pack4(rx_front_slot_q[4],
                        rx_front_slot_q[5], rx_front_slot_q[6],
                        rx_front_slot_q[7]);
                end
                `CAF_OFS_RXBUF + 8'h08: begin
                    rdata_q <= pack4(rx_front_slot_q[8],
                        rx_front_slot_q[9], rx_front_slot_q[10],
                        rx_front_slot_q[11]);
                end
                `CAF_OFS_RXBUF + 8'h0C: begin
                    rdata_q <= pack4(rx_front_slot_q[12],
                        rx_front_slot_q[13], rx_front_slot_q[14],
                        rx_front_slot_q[15]);
                end
                `CAF_OFS_TXBUF: begin
                    rdata_q <= pack4(txbuf_q[0], txbuf_q[1], txbuf_q[2],
                        txbuf_q[3]);
                end
                `CAF_OFS_TXBUF + 8'h04: begin
                    rdata_q <= pack4(txbuf_q[4], txbuf_q[5], txbuf_q[6],
                        txbuf_q[7]);
                end
                `CAF_OFS_TXBUF + 8'h08: begin
                    rdata_q <= pack4(txbuf_q[8], txbuf_q[9], txbuf_q[10],
                        txbuf_q[11]);
                end
                `CAF_OFS_TXBUF + 8'h0C: begin
                    rdata_q <= pack4(txbuf_q[12], txbuf_q[13], txbuf_q[14],
                        txbuf_q[15]);
                end
                default: begin
                    // Unmapped words read as zero, with no bus error
                    rdata_q <= 32'h0000_0000;
                end
            endcase
        end
    end
    assign avs_readdata = rdata_q;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rx_front_full <= 1'b0;
            tx_buffer_rank <= 8'h00;
        end else begin
            rx_front_full <= full_q;
            tx_buffer_rank <= txbuf_q[13]; // R7
        end
    end
endmodule : caf_top

// ---- dv/caf_props.sv ----
/*
 Port checker for caf_top, bound to every instance.
 Assumes one sys_clk domain with synchronous reset sys_rst.
*/
module caf_props
    import caf_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire caf_pkg::caf_rxmsg_t rx_msg,
    input wire logic init_request,
    input wire logic rx_front_full,
    input wire logic [7:0] tx_buffer_rank
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    logic wr_ok;
    assign wr_ok = avs_write && !avs_waitrequest;
    ////////////////////////////////////////////////////////////////////////
    sequence taken_s;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence answer_s;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    bus_answer_a: assert property (taken_s |=> answer_s)
        else $error("bus request not answered after one wait cycle");
    bus_idle_a: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
        else $error("wait low without a request");
    rd_hold_a: assert property ($changed(avs_readdata) |-> $past(avs_read))
        else $error("read data moved without a read");
    test_zero_a: assert property (avs_read && !avs_waitrequest
        && avs_address == 8'h0C |-> avs_readdata == 32'h0)
        else $error("test word readable");
    front_load_a: assert property ($rose(rx_front_full)
        |-> $past(rx_msg.valid, 2))
        else $error("front slot filled without a frame");
    front_free_a: assert property ($fell(rx_front_full) |-> $past(wr_ok
        && avs_address == 8'h08 && avs_writedata[0] && avs_byteenable[0], 2))
        else $error("front slot freed without a clear");
    rank_cause_a: assert property ($changed(tx_buffer_rank)
        |-> $past(wr_ok && avs_address == 8'h8C && avs_byteenable[1], 2))
        else $error("rank moved without a write");
    init_cause_a: assert property ($changed(init_request)
        |-> $past(wr_ok && avs_address == 8'h00))
        else $error("init request moved without a write");
endmodule : caf_props

bind caf_top caf_props props_u (.sys_clk, .sys_rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .rx_msg, .init_request, .rx_front_full,
    .tx_buffer_rank);

// ---- dv/caf_engine_model.sv ----
/*
 Protocol engine stand-in: frames, done events, init acknowledge.
 Assumes the bench calls its tasks from the sys_clk domain.
*/
module caf_engine_model
    import caf_pkg::*;
#(
    parameter int ACK_LAG = 3
)(
    input wire logic sys_clk,
    input wire logic init_request,
    output caf_pkg::caf_rxmsg_t rx_msg,
    output caf_pkg::caf_done_t done_evt,
    output logic init_acknowledge
);
    logic [7:0] lag_q = 8'h00;
    initial begin
        rx_msg = '0;
        done_evt = '0;
        init_acknowledge = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // Slow ack exercises the synchroniser and the init gating
    always @(posedge sys_clk) begin
        lag_q <= (init_request == init_acknowledge) ? 8'h00 : lag_q + 8'h01;
        if (lag_q == 8'(ACK_LAG)) init_acknowledge <= init_request;
    end
    // Idle fields show the inverse so stale values never look valid
    task automatic send_frame(input logic [31:0] id);
        @(posedge sys_clk);
        rx_msg <= '{1'b1, id, 8'h08, {2{id}}};
        @(posedge sys_clk);
        rx_msg <= '{1'b0, ~id, 8'hF7, ~{2{id}}};
    endtask : send_frame
    task automatic send_done(input logic rx, input logic [15:0] tm);
        @(posedge sys_clk);
        done_evt <= '{1'b1, rx, tm};
        @(posedge sys_clk);
        done_evt <= '{1'b0, ~rx, ~tm};
    endtask : send_done
endmodule : caf_engine_model

// ---- dv/tb_can_acceptance_filter_msgbuf.sv ----
/*
 Register-level bench for caf_top with the engine stand-in.
 Assumes caf_pkg, the checker and the model are compiled first.
*/
module tb_can_acceptance_filter_msgbuf import caf_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata, rd;
    logic avs_waitrequest, init_acknowledge, init_request, rx_front_full;
    logic [7:0] tx_buffer_rank;
    caf_rxmsg_t rx_msg;
    caf_done_t done_evt;
    int err_total = 0;
    int comparisons = 0;
    always #5 sys_clk = ~sys_clk;
    caf_top dut_u (.sys_clk, .sys_rst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .rx_msg, .done_evt, .init_acknowledge, .init_request,
        .rx_front_full, .tx_buffer_rank);
    caf_engine_model partner_u (.sys_clk, .init_request, .rx_msg,
        .done_evt, .init_acknowledge);
    ////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : final_report
    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", nm, exp, got);
            err_total++;
        end
    endtask : chk
    task automatic bus(logic wr, logic [7:0] a, logic [31:0] d, logic [3:0] b);
        int n;
        n = 0;
        @(posedge sys_clk);
        {avs_address, avs_writedata, avs_byteenable} <= {a, d, b};
        {avs_write, avs_read} <= {wr, ~wr};
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        rd = avs_readdata;
        {avs_write, avs_read} <= 2'b00;
        if (n >= 40) begin
            err_total++;
            final_report();
        end
    endtask : bus
    task automatic wr(logic [7:0] a, logic [31:0] d);
        bus(1'b1, a, d, 4'hF);
    endtask : wr
    task automatic rdc(string nm, logic [7:0] a, logic [31:0] exp);
        bus(1'b0, a, 32'h0, 4'hF);
        chk(nm, exp, rd);
    endtask : rdc
    task automatic init(logic v);
        int n;
        wr(8'h00, {31'h0, v});
        n = 0;
        do begin
            bus(1'b0, 8'h08, 32'h0, 4'hF);
            n++;
        end while (rd[1] !== v && n < 20);
        chk("init mode", {31'h0, v}, {31'h0, rd[1]});
    endtask : init
    task automatic setup(logic [1:0] org, logic [31:0] mk);
        init(1'b1);
        wr(8'h04, {26'h0, org, 4'h0});
        wr(8'h10, 32'h0);
        wr(8'h14, 32'h44332211);
        wr(8'h20, 32'h0);
        wr(8'h24, mk);
        init(1'b0);
    endtask : setup
    task automatic frame(string nm, logic [31:0] id, logic exp);
        partner_u.send_frame(id);
        repeat (3) @(posedge sys_clk);
        chk(nm, {31'h0, exp}, {31'h0, rx_front_full});
    endtask : frame
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rdc("mask reset", 8'h20, 32'hFFFFFFFF);
        init(1'b0);
        wr(8'h20, 32'h0);
        rdc("mask locked", 8'h20, 32'hFFFFFFFF);
        wr(8'h0C, 32'hFFFFFFFF);
        rdc("test word", 8'h0C, 32'h0);
        rdc("unmapped", 8'h3C, 32'h0);
        $display("access test done");
        for (int m = 0; m < 4; m++) begin
            setup(m[1:0], 32'h0);
            frame("front full", 32'h11223344, m != 3);
            if (m < 3) begin
                bus(1'b0, 8'h04, 32'h0, 4'hF);
                chk("hit", 32'h10 * m + (32'h1 << m), rd & 32'h37);
                rdc("front ident", 8'h40, 32'h44332211);
                wr(8'h08, 32'h1);
            end
            $display("org test %0d done", m);
        end
        setup(2'h0, 32'h0);
        frame("mask reject", 32'h11223345, 1'b0);
        setup(2'h0, 32'h01000000);
        frame("mask accept", 32'h11223345, 1'b1);
        $display("mask test done");
        wr(8'h00, 32'h2);
        partner_u.send_done(1'b0, 16'hBEEF);
        partner_u.send_done(1'b1, 16'h1234);
        bus(1'b0, 8'h8C, 32'h0, 4'hF);
        chk("tx stamp", 32'hEFBE, {16'h0, rd[31:16]});
        bus(1'b0, 8'h4C, 32'h0, 4'hF);
        chk("rx stamp", 32'h3412, {16'h0, rd[31:16]});
        bus(1'b1, 8'h8C, 32'h00005A00, 4'hE);
        bus(1'b0, 8'h8C, 32'h0, 4'hF);
        chk("stamp kept", 32'hEFBE5A, {8'h0, rd[31:8]});
        chk("rank", 32'h5A, {24'h0, tx_buffer_rank});
        $display("stamp test done");
        final_report();
    end
endmodule : tb_can_acceptance_filter_msgbuf
